// ---- cfh_pkg.sv ----
/*
 * Shared constants for the host-side card pin controller: card modes, access sizes,
 * state codes and the strobe timing counts.
 * Assumes a single 100 MHz clock and a card wired pin for pin to the top module.
 */
package cfh_pkg;

    typedef logic [1:0] cfh_mode_t;
    localparam cfh_mode_t MODE_MEM = 2'h0;
    localparam cfh_mode_t MODE_IO  = 2'h1;
    localparam cfh_mode_t MODE_IDE = 2'h2;

    typedef logic [1:0] cfh_size_t;
    localparam cfh_size_t SIZE_WORD = 2'h0;
    localparam cfh_size_t SIZE_EVEN = 2'h1;
    localparam cfh_size_t SIZE_ODD  = 2'h2;

    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int TMR_W  = 8;

    // Strobe phase lengths, least times rounded up to whole cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS      = 30;
    localparam int STROBE_NS     = 150;
    localparam int HOLD_NS       = 20;
    localparam logic [TMR_W-1:0] SETUP_CYC  = TMR_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] STROBE_CYC = TMR_W'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] HOLD_CYC   = TMR_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [4:0] {
        ST_INIT   = 5'h01,
        ST_IDLE   = 5'h02,
        ST_SETUP  = 5'h04,
        ST_STROBE = 5'h08,
        ST_HOLD   = 5'h10
    } cfh_state_e;

    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [TMR_W-1:0]  TMR_ZERO  = 8'h00;
    localparam logic [TMR_W-1:0]  TMR_ONE   = 8'h01;

endpackage

// ---- cfh_tmr_if.sv ----
/*
 * Interface between the access sequencer and its phase timer.
 * Assumes both ends share the controller clock.
 */
`timescale 1ns/1ns
interface cfh_tmr_if;
    logic                         start;
    logic [cfh_pkg::TMR_W-1:0]    count;
    logic                         done;

    modport owner (output start, output count, input done);
    modport timer (input start, input count, output done);
endinterface

// ---- cfh_phase_timer.sv ----
/*
 * Phase timer: loads a count on a start pulse and pulses done when it has run out.
 * Assumes start is a one-cycle pulse and is not repeated while a count runs.
 */
`timescale 1ns/1ns
module cfh_phase_timer (
    input  wire logic    clk,
    input  wire logic    rst_n,
    cfh_tmr_if.timer     tmr
);
    logic [cfh_pkg::TMR_W-1:0] cnt_q;
    logic [cfh_pkg::TMR_W-1:0] cnt_d;
    logic                      done_q;
    logic                      done_d;

    // Counts down to zero and flags the last step.
    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (tmr.start) begin
            cnt_d = tmr.count;
        end else if (cnt_q != cfh_pkg::TMR_ZERO) begin
            cnt_d  = cnt_q - cfh_pkg::TMR_ONE;
            done_d = (cnt_q == cfh_pkg::TMR_ONE);
        end
    end

    // Registers the count and the done pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= cfh_pkg::TMR_ZERO;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign tmr.done = done_q;
endmodule

// ---- cfh_host.sv ----
/*
 * Host controller for a flash card in memory, I/O or IDE mode: runs one card access at a
 * time from a command port, drives the card pins from flip-flops and interprets the shared
 * ready/interrupt pin per mode.
 * Assumes card pins are synchronous to CLK and the card is powered while RST_N is released.
 */
`timescale 1ns/1ns
module cfh_host (
    input  wire logic                          CLK,
    input  wire logic                          RST_N,
    input  wire logic [1:0]                    MODE,
    input  wire logic                          MASTER,
    input  wire logic                          CFG_DONE,
    input  wire logic                          CMD_VALID,
    input  wire logic                          CMD_WRITE,
    input  wire logic                          CMD_TASK,
    input  wire logic                          CMD_ALT,
    input  wire logic [1:0]                    CMD_SIZE,
    input  wire logic [cfh_pkg::ADDR_W-1:0]    CMD_ADDR,
    input  wire logic [cfh_pkg::DATA_W-1:0]    CMD_WDATA,
    output logic                               CMD_READY,
    output logic                               CMD_DONE,
    output logic                               CMD_ERR,
    output logic [cfh_pkg::DATA_W-1:0]         RDATA,
    output logic                               NOACK,
    output logic                               CARD_READY,
    output logic                               CARD_INT,
    output logic [cfh_pkg::ADDR_W-1:0]         ADDR,
    input  wire logic [cfh_pkg::DATA_W-1:0]    DATA_I,
    output logic [cfh_pkg::DATA_W-1:0]         DATA_O,
    output logic                               DATA_OE,
    output logic                               CARD_ENABLE_LOW_N,
    output logic                               CARD_ENABLE_HIGH_N,
    output logic                               OUTPUT_ENABLE_N,
    output logic                               WRITE_ENABLE_N,
    output logic                               IO_READ_STROBE_N,
    output logic                               IO_WRITE_STROBE_N,
    output logic                               ATTRIBUTE_SELECT_N,
    output logic                               IDE_MODE_SELECT_N,
    output logic                               DRIVE_ROLE_SELECT_N_O,
    output logic                               DRIVE_ROLE_SELECT_N_OE,
    input  wire logic                          READY_BUSY_N,
    input  wire logic                          INPUT_ACKNOWLEDGE_N
);
    cfh_tmr_if tmr ();

    cfh_phase_timer u_timer (
        .clk   (CLK),
        .rst_n (RST_N),
        .tmr   (tmr)
    );

    cfh_pkg::cfh_state_e                state_q, state_d;
    cfh_pkg::cfh_mode_t                 mode_q, mode_d;
    logic                               start_q, start_d;
    logic [cfh_pkg::TMR_W-1:0]          count_q, count_d;
    logic                               write_q, write_d;
    logic                               use_io_q, use_io_d;
    cfh_pkg::cfh_size_t                 size_q, size_d;
    logic                               ready_q, ready_d;
    logic                               done_q, done_d;
    logic                               err_q, err_d;
    logic [cfh_pkg::DATA_W-1:0]         rdata_q, rdata_d;
    logic                               noack_q, noack_d;
    logic                               card_ready_q, card_ready_d;
    logic                               card_int_q, card_int_d;
    logic [cfh_pkg::ADDR_W-1:0]         addr_q, addr_d;
    logic [cfh_pkg::DATA_W-1:0]         dout_q, dout_d;
    logic                               doe_q, doe_d;
    logic                               cel_n_q, cel_n_d;
    logic                               ceh_n_q, ceh_n_d;
    logic                               oe_n_q, oe_n_d;
    logic                               we_n_q, we_n_d;
    logic                               ior_n_q, ior_n_d;
    logic                               iow_n_q, iow_n_d;
    logic                               reg_n_q, reg_n_d;
    logic                               ide_sel_n_q, ide_sel_n_d;
    logic                               role_oe_q, role_oe_d;
    logic                               cmd_io;
    logic                               cmd_bad;

    assign tmr.start = start_q;
    assign tmr.count = count_q;

    // Decides the strobe pair and legality of the offered command in the current mode.
    always_comb begin
        cmd_io  = (mode_q == cfh_pkg::MODE_IDE) || ((mode_q == cfh_pkg::MODE_IO) && CMD_TASK);
        cmd_bad = ((mode_q != cfh_pkg::MODE_MEM) && (mode_q != cfh_pkg::MODE_IO)
                   && (mode_q != cfh_pkg::MODE_IDE))
                  || (cmd_io && !CFG_DONE)
                  || ((mode_q == cfh_pkg::MODE_IDE) && !CMD_TASK)
                  || ((CMD_SIZE != cfh_pkg::SIZE_WORD) && (CMD_SIZE != cfh_pkg::SIZE_EVEN)
                      && (CMD_SIZE != cfh_pkg::SIZE_ODD));
    end

    // Sequencer: initialization wait, then setup, strobe and hold phases per access.
    always_comb begin
        state_d      = state_q;
        mode_d       = mode_q;
        start_d      = 1'b0;
        count_d      = count_q;
        write_d      = write_q;
        use_io_d     = use_io_q;
        size_d       = size_q;
        ready_d      = 1'b0;
        done_d       = 1'b0;
        err_d        = 1'b0;
        rdata_d      = rdata_q;
        noack_d      = noack_q;
        addr_d       = addr_q;
        dout_d       = dout_q;
        doe_d        = doe_q;
        cel_n_d      = cel_n_q;
        ceh_n_d      = ceh_n_q;
        oe_n_d       = oe_n_q;
        we_n_d       = we_n_q;
        ior_n_d      = ior_n_q;
        iow_n_d      = iow_n_q;
        reg_n_d      = reg_n_q;
        ide_sel_n_d  = (mode_q != cfh_pkg::MODE_IDE);
        role_oe_d    = MASTER;
        // Interpret the shared status pin by mode.
        card_ready_d = (mode_q == cfh_pkg::MODE_MEM) ? READY_BUSY_N : 1'b1;
        card_int_d   = 1'b0;
        if (mode_q == cfh_pkg::MODE_IO) begin
            card_int_d = !READY_BUSY_N;
        end else if (mode_q == cfh_pkg::MODE_IDE) begin
            card_int_d = READY_BUSY_N;
        end
        case (state_q)
            cfh_pkg::ST_INIT: begin
                mode_d = MODE;
                if ((mode_q != cfh_pkg::MODE_MEM) || READY_BUSY_N) begin
                    state_d = cfh_pkg::ST_IDLE;
                    ready_d = 1'b1;
                end
            end
            cfh_pkg::ST_IDLE: begin
                ready_d = 1'b1;
                if (CMD_VALID && cmd_bad) begin
                    err_d = 1'b1;
                end else if (CMD_VALID) begin
                    ready_d  = 1'b0;
                    state_d  = cfh_pkg::ST_SETUP;
                    start_d  = 1'b1;
                    count_d  = cfh_pkg::SETUP_CYC;
                    write_d  = CMD_WRITE;
                    use_io_d = cmd_io;
                    size_d   = CMD_SIZE;
                    noack_d  = 1'b0;
                    addr_d   = CMD_ADDR;
                    doe_d    = CMD_WRITE;
                    dout_d   = CMD_WDATA;
                    if (mode_q == cfh_pkg::MODE_IDE) begin
                        cel_n_d = CMD_ALT;
                        ceh_n_d = !CMD_ALT;
                        reg_n_d = 1'b1;
                    end else begin
                        cel_n_d = (CMD_SIZE == cfh_pkg::SIZE_ODD);
                        ceh_n_d = (CMD_SIZE == cfh_pkg::SIZE_EVEN);
                        reg_n_d = (mode_q == cfh_pkg::MODE_MEM) && CMD_TASK;
                        if (CMD_SIZE == cfh_pkg::SIZE_ODD) begin
                            dout_d = {CMD_WDATA[cfh_pkg::BYTE_W-1:0], cfh_pkg::BYTE_ZERO};
                        end
                    end
                end else begin
                    mode_d = MODE;
                    if (MODE != mode_q) begin
                        state_d = cfh_pkg::ST_INIT;
                        ready_d = 1'b0;
                    end
                end
            end
            cfh_pkg::ST_SETUP: begin
                if (tmr.done) begin
                    state_d = cfh_pkg::ST_STROBE;
                    start_d = 1'b1;
                    count_d = cfh_pkg::STROBE_CYC;
                    if (use_io_q) begin
                        ior_n_d = write_q;
                        iow_n_d = !write_q;
                    end else begin
                        oe_n_d = write_q;
                        we_n_d = !write_q;
                    end
                end
            end
            cfh_pkg::ST_STROBE: begin
                if (tmr.done) begin
                    state_d  = cfh_pkg::ST_HOLD;
                    start_d  = 1'b1;
                    count_d  = cfh_pkg::HOLD_CYC;
                    oe_n_d   = 1'b1;
                    we_n_d   = 1'b1;
                    ior_n_d  = 1'b1;
                    iow_n_d  = 1'b1;
                    if (!write_q) begin
                        rdata_d = DATA_I;
                        if (size_q == cfh_pkg::SIZE_ODD) begin
                            rdata_d = {cfh_pkg::BYTE_ZERO, DATA_I[cfh_pkg::DATA_W-1:cfh_pkg::BYTE_W]};
                        end else if (size_q == cfh_pkg::SIZE_EVEN) begin
                            rdata_d = {cfh_pkg::BYTE_ZERO, DATA_I[cfh_pkg::BYTE_W-1:0]};
                        end
                        // A selected I/O read must be acknowledged by the card.
                        noack_d = use_io_q && (mode_q == cfh_pkg::MODE_IO) && INPUT_ACKNOWLEDGE_N;
                    end
                end
            end
            cfh_pkg::ST_HOLD: begin
                if (tmr.done) begin
                    state_d = cfh_pkg::ST_IDLE;
                    ready_d = 1'b1;
                    done_d  = 1'b1;
                    doe_d   = 1'b0;
                    cel_n_d = 1'b1;
                    ceh_n_d = 1'b1;
                    reg_n_d = 1'b1;
                end
            end
            default: begin
                state_d = cfh_pkg::ST_INIT;
            end
        endcase
    end

    // Registers every piece of sequencer state and every pin except the constant role pin level.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q      <= cfh_pkg::ST_INIT;
            mode_q       <= cfh_pkg::MODE_MEM;
            start_q      <= 1'b0;
            count_q      <= cfh_pkg::TMR_ZERO;
            write_q      <= 1'b0;
            use_io_q     <= 1'b0;
            size_q       <= cfh_pkg::SIZE_WORD;
            ready_q      <= 1'b0;
            done_q       <= 1'b0;
            err_q        <= 1'b0;
            rdata_q      <= '0;
            noack_q      <= 1'b0;
            card_ready_q <= 1'b0;
            card_int_q   <= 1'b0;
            addr_q       <= '0;
            dout_q       <= '0;
            doe_q        <= 1'b0;
            cel_n_q      <= 1'b1;
            ceh_n_q      <= 1'b1;
            oe_n_q       <= 1'b1;
            we_n_q       <= 1'b1;
            ior_n_q      <= 1'b1;
            iow_n_q      <= 1'b1;
            reg_n_q      <= 1'b1;
            ide_sel_n_q  <= 1'b1;
            role_oe_q    <= 1'b0;
        end else begin
            state_q      <= state_d;
            mode_q       <= mode_d;
            start_q      <= start_d;
            count_q      <= count_d;
            write_q      <= write_d;
            use_io_q     <= use_io_d;
            size_q       <= size_d;
            ready_q      <= ready_d;
            done_q       <= done_d;
            err_q        <= err_d;
            rdata_q      <= rdata_d;
            noack_q      <= noack_d;
            card_ready_q <= card_ready_d;
            card_int_q   <= card_int_d;
            addr_q       <= addr_d;
            dout_q       <= dout_d;
            doe_q        <= doe_d;
            cel_n_q      <= cel_n_d;
            ceh_n_q      <= ceh_n_d;
            oe_n_q       <= oe_n_d;
            we_n_q       <= we_n_d;
            ior_n_q      <= ior_n_d;
            iow_n_q      <= iow_n_d;
            reg_n_q      <= reg_n_d;
            ide_sel_n_q  <= ide_sel_n_d;
            role_oe_q    <= role_oe_d;
        end
    end

    // Outputs come straight from the registers above, except the role pin level, which is a constant low.
    assign CMD_READY              = ready_q;
    assign CMD_DONE               = done_q;
    assign CMD_ERR                = err_q;
    assign RDATA                  = rdata_q;
    assign NOACK                  = noack_q;
    assign CARD_READY             = card_ready_q;
    assign CARD_INT               = card_int_q;
    assign ADDR                   = addr_q;
    assign DATA_O                 = dout_q;
    assign DATA_OE                = doe_q;
    assign CARD_ENABLE_LOW_N      = cel_n_q;
    assign CARD_ENABLE_HIGH_N     = ceh_n_q;
    assign OUTPUT_ENABLE_N        = oe_n_q;
    assign WRITE_ENABLE_N         = we_n_q;
    assign IO_READ_STROBE_N       = ior_n_q;
    assign IO_WRITE_STROBE_N      = iow_n_q;
    assign ATTRIBUTE_SELECT_N     = reg_n_q;
    assign IDE_MODE_SELECT_N      = ide_sel_n_q;
    assign DRIVE_ROLE_SELECT_N_O  = 1'b0;           // Open drain: only ever pulls to ground.
    assign DRIVE_ROLE_SELECT_N_OE = role_oe_q;
endmodule

// ---- cfh_host_props.sv ----
/*
 * Concurrent checks on the card pins of the host controller.
 * Assumes it is bound to cfh_host and sees only that module's ports.
 */
`timescale 1ns/1ns
module cfh_host_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic MASTER,
    input wire logic CFG_DONE,
    input wire logic CMD_DONE,
    input wire logic NOACK,
    input wire logic CARD_INT,
    input wire logic CARD_ENABLE_LOW_N,
    input wire logic CARD_ENABLE_HIGH_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic WRITE_ENABLE_N,
    input wire logic IO_READ_STROBE_N,
    input wire logic IO_WRITE_STROBE_N,
    input wire logic ATTRIBUTE_SELECT_N,
    input wire logic IDE_MODE_SELECT_N,
    input wire logic DRIVE_ROLE_SELECT_N_OE,
    input wire logic READY_BUSY_N,
    input wire logic INPUT_ACKNOWLEDGE_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // The role pin is grounded exactly when the master role was asked for a cycle earlier.
    role_follow_a: assert property ($past(RST_N) |-> DRIVE_ROLE_SELECT_N_OE == $past(MASTER))
        else $error("role pin drive does not follow master request");
    // I/O strobes appear only once configured and only in I/O or IDE mode.
    io_strobe_gate_a: assert property ((!IO_READ_STROBE_N || !IO_WRITE_STROBE_N) |->
        CFG_DONE && (!IDE_MODE_SELECT_N || !ATTRIBUTE_SELECT_N)) else $error("I/O strobe out of place");
    // In I/O mode the attribute select stays low on task file cycles.
    io_attr_low_a: assert property ((!IO_READ_STROBE_N || !IO_WRITE_STROBE_N) && IDE_MODE_SELECT_N
        |-> !ATTRIBUTE_SELECT_N) else $error("attribute select high on I/O cycle");
    // In IDE mode the memory strobes stay idle and the attribute select stays high.
    ide_pins_a: assert property (!IDE_MODE_SELECT_N |-> ATTRIBUTE_SELECT_N
        && WRITE_ENABLE_N && OUTPUT_ENABLE_N) else $error("memory pin used in IDE");
    // IDE cycles use one enable at a time.
    ide_one_enable_a: assert property (!IDE_MODE_SELECT_N |-> CARD_ENABLE_LOW_N || CARD_ENABLE_HIGH_N)
        else $error("both enables low in IDE mode");
    // Every strobe falls inside an enabled cycle.
    strobe_enabled_a: assert property ((!OUTPUT_ENABLE_N || !WRITE_ENABLE_N || !IO_READ_STROBE_N ||
        !IO_WRITE_STROBE_N) |-> !(CARD_ENABLE_LOW_N && CARD_ENABLE_HIGH_N)) else $error("strobe without enable");
    // The missing-acknowledge flag records the acknowledge seen at the end of an I/O mode read.
    ack_flag_a: assert property ($rose(IO_READ_STROBE_N) && IDE_MODE_SELECT_N |->
        NOACK == $past(INPUT_ACKNOWLEDGE_N)) else $error("acknowledge flag wrong");
    // In IDE mode the interrupt pin is active high.
    ide_int_a: assert property (!IDE_MODE_SELECT_N |-> CARD_INT == $past(READY_BUSY_N))
        else $error("IDE interrupt polarity wrong");
    // An I/O read strobe lasts 17 cycles and the access completes 4 cycles after it ends.
    strobe_len_a: assert property ($fell(IO_READ_STROBE_N) |-> !IO_READ_STROBE_N [*8] ##10
        $rose(IO_READ_STROBE_N) ##4 CMD_DONE) else $error("I/O read strobe length wrong");

    // Main access kinds.
    cover property (!IDE_MODE_SELECT_N && !CARD_ENABLE_HIGH_N && !IO_READ_STROBE_N);
    cover property (IDE_MODE_SELECT_N && !IO_READ_STROBE_N);
    cover property (!OUTPUT_ENABLE_N && ATTRIBUTE_SELECT_N);
endmodule

bind cfh_host cfh_host_props i_cfh_host_props (.*);

// ---- cfh_card_model.sv ----
/*
 * Behavioural card: register banks, mode-dependent strobes and the shared status pin.
 * Assumes pins synchronous to CLK; busy time and interrupt are set by the bench.
 */
`timescale 1ns/1ns
module cfh_card_model (
    input  wire logic                       CLK,
    input  wire logic                       RST_N,
    input  wire logic                       IO_MODE,
    input  wire logic                       CFG_DONE,
    input  wire logic                       IRQ,
    input  wire logic [7:0]                 BUSY_CYC,
    input  wire logic [cfh_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [15:0]                DATA_O,
    input  wire logic                       CARD_ENABLE_LOW_N,
    input  wire logic                       CARD_ENABLE_HIGH_N,
    input  wire logic                       OUTPUT_ENABLE_N,
    input  wire logic                       WRITE_ENABLE_N,
    input  wire logic                       IO_READ_STROBE_N,
    input  wire logic                       IO_WRITE_STROBE_N,
    input  wire logic                       ATTRIBUTE_SELECT_N,
    input  wire logic                       IDE_MODE_SELECT_N,
    input  wire logic                       DRIVE_ROLE_SELECT_N,
    output logic [15:0]                     DATA_I,
    output logic                            READY_BUSY_N,
    output logic                            INPUT_ACKNOWLEDGE_N,
    output logic                            IS_MASTER
);
    logic [15:0] mem_q [0:15];
    logic [7:0]  busy_q;
    logic [7:0]  cyc_q;
    logic        ide, sel, ior, iow, rd, wr, sp;
    logic [3:0]  ix;

    // Decodes mode, enables and qualified strobes; I/O strobes count only once configured.
    always_comb begin
        ide  = !IDE_MODE_SELECT_N;
        sel  = !CARD_ENABLE_LOW_N || !CARD_ENABLE_HIGH_N;
        ior  = !IO_READ_STROBE_N && CFG_DONE && (IO_MODE || ide);
        iow  = !IO_WRITE_STROBE_N && CFG_DONE && (IO_MODE || ide);
        rd   = sel && (ior || (!OUTPUT_ENABLE_N && !ide));
        wr   = sel && (iow || (!WRITE_ENABLE_N && !ide));
        sp   = ide ? !CARD_ENABLE_HIGH_N : (IO_MODE ? (ior || iow) : ATTRIBUTE_SELECT_N);
        ix   = {sp, ADDR[2:0]};
    end

    // A released bus shows a pattern that changes every cycle, never the last value.
    assign DATA_I = rd ? mem_q[ix] : {cyc_q, ~cyc_q};
    assign READY_BUSY_N = ide ? IRQ : (IO_MODE ? !IRQ : (busy_q == 8'h00));
    assign INPUT_ACKNOWLEDGE_N = !(IO_MODE && !ide && sel && ior);
    assign IS_MASTER = ide && !DRIVE_ROLE_SELECT_N;

    // Busy countdown after reset and byte-lane writes; IDE always takes the full word.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_q <= BUSY_CYC;
            cyc_q  <= 8'h00;
        end else begin
            cyc_q <= cyc_q + 8'h01;
            if (busy_q != 8'h00) busy_q <= busy_q - 8'h01;
            if (wr && (ide || !CARD_ENABLE_LOW_N)) mem_q[ix][7:0] <= DATA_O[7:0];
            if (wr && (ide || !CARD_ENABLE_HIGH_N)) mem_q[ix][15:8] <= DATA_O[15:8];
        end
    end
endmodule

// ---- cfh_host_bench.sv ----
/*
 * Self-checking bench for cfh_host against the behavioural card in all three modes.
 * Assumes cfh_host_props is bound in and the card model sits on the pins.
 */
`timescale 1ns/1ns
module cfh_host_bench;
    logic        CLK, RST_N, MASTER, CFG_DONE, CMD_VALID, CMD_WRITE, CMD_TASK, CMD_ALT, IO_MODE, IRQ;
    logic [1:0]  MODE, CMD_SIZE;
    logic [7:0]  BUSY_CYC;
    logic [10:0] CMD_ADDR, ADDR;
    logic [15:0] CMD_WDATA, RDATA, DATA_I, DATA_O;
    logic        CMD_READY, CMD_DONE, CMD_ERR, NOACK, CARD_READY, CARD_INT, DATA_OE, IS_MASTER;
    logic        CARD_ENABLE_LOW_N, CARD_ENABLE_HIGH_N, OUTPUT_ENABLE_N, WRITE_ENABLE_N;
    logic        IO_READ_STROBE_N, IO_WRITE_STROBE_N, ATTRIBUTE_SELECT_N, IDE_MODE_SELECT_N;
    logic        DRIVE_ROLE_SELECT_N_O, DRIVE_ROLE_SELECT_N_OE, READY_BUSY_N, INPUT_ACKNOWLEDGE_N;
    wire         DRIVE_ROLE_SELECT_N;
    int          failures, n_compared;

    // The role pin floats high when the host does not ground it.
    assign DRIVE_ROLE_SELECT_N = DRIVE_ROLE_SELECT_N_OE ? DRIVE_ROLE_SELECT_N_O : 1'b1;

    cfh_host i_cfh_host (.*);
    cfh_card_model i_cfh_card_model (.*);

    // Free-running 100 MHz clock.
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task end_of_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Runs one command and checks whether it was refused as expected.
    task cmd(input logic w, t, a, input logic [1:0] sz, input logic [10:0] ad, input logic [15:0] wd,
             input logic err);
        int n;
        n = 0;
        while (CMD_READY !== 1'b1 && n < 300) begin tick(1); n++; end
        if (n >= 300) begin failures++; end_of_test; end
        {CMD_WRITE, CMD_TASK, CMD_ALT, CMD_SIZE, CMD_ADDR, CMD_WDATA} = {w, t, a, sz, ad, wd};
        CMD_VALID = 1'b1;
        tick(1);
        CMD_VALID = 1'b0;
        n = 0;
        while (CMD_DONE !== 1'b1 && CMD_ERR !== 1'b1 && n < 100) begin tick(1); n++; end
        if (n >= 100) begin failures++; end_of_test; end
        chk("refusal", err, CMD_ERR);
    endtask

    // Commands wait out the card's internal initialisation after reset.
    task t_busy;
        int n;
        n = 0;
        chk("ready_during_init", 1'b0, CARD_READY);
        while (CMD_READY !== 1'b1 && n < 300) begin tick(1); n++; end
        if (n >= 300) begin failures++; end_of_test; end
        chk("waited_for_ready", 1'b1, n >= 40);
        chk("ready_after_init", 1'b1, CARD_READY);
    endtask

    // Memory mode: separate spaces by attribute select, byte lanes, refused size.
    task t_mem;
        cmd(1, 1, 0, 2'h0, 11'h001, 16'ha55a, 0);
        cmd(1, 0, 0, 2'h0, 11'h001, 16'h1234, 0);
        cmd(0, 1, 0, 2'h0, 11'h001, 16'h0000, 0); chk("mem_task", 16'ha55a, RDATA);
        cmd(0, 0, 0, 2'h0, 11'h001, 16'h0000, 0); chk("mem_attr", 16'h1234, RDATA);
        cmd(1, 1, 0, 2'h1, 11'h002, 16'h0011, 0);
        cmd(1, 1, 0, 2'h2, 11'h002, 16'h0022, 0);
        cmd(0, 1, 0, 2'h0, 11'h002, 16'h0000, 0); chk("lanes", 16'h2211, RDATA);
        cmd(0, 1, 0, 2'h2, 11'h002, 16'h0000, 0); chk("odd_byte", 16'h0022, RDATA);
        cmd(0, 1, 0, 2'h3, 11'h002, 16'h0000, 1);
    endtask

    // I/O mode: strobes refused until configured, acknowledge, attribute by output enable, interrupt.
    task t_io;
        MODE = 2'h1;
        IO_MODE = 1'b1;
        CFG_DONE = 1'b0;
        tick(3);
        cmd(1, 1, 0, 2'h0, 11'h004, 16'h0f0f, 1);
        cmd(0, 1, 0, 2'h0, 11'h004, 16'h0000, 1);
        CFG_DONE = 1'b1;
        cmd(1, 1, 0, 2'h0, 11'h004, 16'h0f0f, 0);
        cmd(0, 1, 0, 2'h0, 11'h004, 16'h0000, 0); chk("io_task", 16'h0f0f, RDATA);
        chk("noack", 1'b0, NOACK);
        cmd(0, 0, 0, 2'h0, 11'h001, 16'h0000, 0); chk("io_attr", 16'h1234, RDATA);
        IRQ = 1'b1;
        tick(2); chk("io_int_on", 1'b1, CARD_INT);
        IRQ = 1'b0;
        tick(2); chk("io_int_off", 1'b0, CARD_INT);
    endtask

    // IDE mode: select pin, drive role, alternate registers, refused attribute, interrupt.
    task t_ide;
        MODE = 2'h2;
        IO_MODE = 1'b0;
        tick(3); chk("ide_select", 1'b0, IDE_MODE_SELECT_N);
        chk("ide_attr_high", 1'b1, ATTRIBUTE_SELECT_N);
        MASTER = 1'b1;
        tick(2); chk("master", 1'b1, IS_MASTER);
        MASTER = 1'b0;
        tick(2); chk("slave", 1'b0, IS_MASTER);
        cmd(1, 1, 0, 2'h0, 11'h003, 16'hbeef, 0);
        cmd(1, 1, 1, 2'h0, 11'h003, 16'hcafe, 0);
        cmd(0, 1, 0, 2'h0, 11'h003, 16'h0000, 0); chk("ide_task", 16'hbeef, RDATA);
        cmd(0, 1, 1, 2'h0, 11'h003, 16'h0000, 0); chk("ide_alt", 16'hcafe, RDATA);
        cmd(0, 0, 0, 2'h0, 11'h001, 16'h0000, 1);
        IRQ = 1'b1;
        tick(2); chk("ide_int", 1'b1, CARD_INT);
    endtask

    // Reset for 20 cycles, then run the scenarios in turn.
    initial begin
        {RST_N, MASTER, CFG_DONE, CMD_VALID, CMD_WRITE, CMD_TASK, CMD_ALT, IO_MODE, IRQ} = '0;
        {MODE, CMD_SIZE, CMD_ADDR, CMD_WDATA} = '0;
        BUSY_CYC = 8'h28;
        failures = 0;
        n_compared = 0;
        tick(20);
        RST_N = 1'b1;
        t_busy;
        t_mem;
        t_io;
        t_ide;
        end_of_test;
    end
endmodule
